// >>> include/core_data_regs.vh
// Address map, field positions and reset values for the core data space decoder.
`ifndef CORE_DATA_REGS_VH
`define CORE_DATA_REGS_VH
`define ADDR_PORT_ZERO_LATCH 8'h80
`define ADDR_STACK_POINTER 8'h81
`define ADDR_PORT_ONE_LATCH 8'h90
`define ADDR_STATUS_WORD 8'hd0
`define ADDR_ARITH_RESULT 8'he0
`define ADDR_MULTIPLY_HIGH 8'hf0
`define RST_STACK_POINTER 8'h07
`define RST_PORT_LATCH 8'hff
`define RST_ZERO_BYTE 8'h00
`define BIT_AREA_BASE 8'h20
`define GENERAL_AREA_BASE 8'h30
`define UPPER_AREA_BASE 8'h80
`define STATUS_CARRY_BIT 7
`define STATUS_BANK_HI 4
`define STATUS_BANK_LO 3
`define OP_NONE 3'h0
`define OP_DIRECT 3'h1
`define OP_INDIRECT 3'h2
`define OP_WORKREG 3'h3
`define OP_BIT 3'h4
`define OP_PUSH 3'h5
`define OP_POP 3'h6
`define OP_MULTIPLY 3'h7
`endif

// >>> rtl/core_data_space_decoder.v
// Decoder of the core internal data space: scratchpad bytes, working registers, bits and core SFRs.
//
// What this block does
// - A direct address from 80h to FFh always goes to SFR space, defined register or not.
// - Scratchpad bytes 80h to FFh are reached only by indirect or stack accesses, never directly.
// - Scratchpad bytes 30h to 7Fh answer to both direct and indirect addressing.
// - Bit numbers 00h to 7Fh select byte 20h plus n/8, bit n mod 8.
// - Bit numbers 80h to FFh select the SFR at the upper five bits with three zeros, bit by the low three.
// - SFRs at addresses ending in three zero bits work both as bytes and as single bits.
// - Bytes 00h to 1Fh are four banks of eight working registers, at eight times bank plus index.
// - Only working registers zero and one serve as 8-bit indirect pointers over the full scratchpad.
// - An unassigned SFR reads 00h and ignores writes.
// - Every SFR is read and written one byte per access.
// - The stack pointer resets to 07h.
// - A push increments the stack pointer first, then writes the scratchpad at the new value.
// - A pop reads the scratchpad at the stack pointer, delivers it, then decrements the pointer.
// - An unsigned multiply puts the low product byte in the accumulator and the high byte in B.
// - The carry flag is bit 7 of the status word and can be changed by bit accesses.
`timescale 1ns/10ps
`include "core_data_regs.vh"
module core_data_space_decoder (
   input wire sys_clk,
   input wire reset_n,
   input wire reqValid,
   input wire [2:0] reqOp,
   input wire reqWrite,
   input wire [7:0] reqAddr,
   input wire [7:0] reqData,
   input wire reqBitValue,
   output reg [7:0] rspData_q,
   output reg rspBit_q,
   output reg rspValid_q,
   output reg [7:0] portZeroOut_q,
   output reg [7:0] portOneOut_q,
   output reg [7:0] stackPointerOut_q,
   output reg carryOut_q
);
   reg [7:0] stack_pointer_q;
   reg [7:0] port_zero_latch_q;
   reg [7:0] port_one_latch_q;
   reg [7:0] status_word_q;
   reg [7:0] arith_result_reg_q;
   reg [7:0] multiply_high_reg_q;

   // Bank select is read live from the status word, so a bank switch acts on the very next request.
   wire [1:0] bankSel = status_word_q[`STATUS_BANK_HI:`STATUS_BANK_LO];
   wire [7:0] workRegAddr = {3'h0, bankSel, reqAddr[2:0]};
   // Pointer registers sit at bank base plus 0 or 1; only bit 0 of the index is used.
   wire [7:0] pointerAddr = {3'h0, bankSel, 2'h0, reqAddr[0]};
   // The pointer wraps modulo 256, exactly as the 8-bit register itself does.
   wire [7:0] spInc = stack_pointer_q + 8'h01;
   wire [7:0] spDec = stack_pointer_q - 8'h01;
   // Both factors are widened first so that the high byte of the product is never lost.
   wire [15:0] product = {8'h00, arith_result_reg_q} * {8'h00, multiply_high_reg_q};

   // Direct addresses in the upper half always mean SFR space, defined register or not.
   wire directToSfr = reqAddr[7];

   // Bit address split: lower half to the bit area, upper half to base SFRs.
   wire bitInSfr = reqAddr[7];
   wire [7:0] bitByteAddr = bitInSfr ? {reqAddr[7:3], 3'h0}
      : (`BIT_AREA_BASE + {4'h0, reqAddr[6:3]});
   wire [2:0] bitPos = reqAddr[2:0];

   wire [7:0] ramRdA;
   wire [7:0] ramRdB;
   reg [7:0] ramRdAddrA;
   reg ramWe;
   reg [7:0] ramWAddr;
   reg [7:0] ramWData;

   // Pointer value fetched from the working register for indirect ops.
   always @* begin
      case (reqOp)
         `OP_INDIRECT: ramRdAddrA = pointerAddr;
         `OP_WORKREG: ramRdAddrA = workRegAddr;
         `OP_BIT: ramRdAddrA = bitByteAddr;
         `OP_POP: ramRdAddrA = stack_pointer_q;
         default: ramRdAddrA = reqAddr;
      endcase
   end

   // Port B reads the byte that port A points at, so an indirect access costs no extra cycle.
   scratch_ram #(.DEPTH(256)) uRam (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .writeEn(ramWe),
      .writeAddr(ramWAddr),
      .writeData(ramWData),
      .readAddrA(ramRdAddrA),
      .readDataA(ramRdA),
      .readAddrB(ramRdA),
      .readDataB(ramRdB)
   );

   // SFR byte read; unassigned addresses give zero.
   function [7:0] sfrRead;
      input [7:0] a;
      begin
         case (a)
            `ADDR_PORT_ZERO_LATCH: sfrRead = port_zero_latch_q;
            `ADDR_STACK_POINTER: sfrRead = stack_pointer_q;
            `ADDR_PORT_ONE_LATCH: sfrRead = port_one_latch_q;
            `ADDR_STATUS_WORD: sfrRead = status_word_q;
            `ADDR_ARITH_RESULT: sfrRead = arith_result_reg_q;
            `ADDR_MULTIPLY_HIGH: sfrRead = multiply_high_reg_q;
            default: sfrRead = `RST_ZERO_BYTE;
         endcase
      end
   endfunction

   reg sfrWe;
   reg [7:0] sfrWAddr;
   reg [7:0] sfrWData;
   reg spPush;
   reg spPop;
   reg mulDo;
   reg [7:0] rdData;
   reg [7:0] bitByte;
   reg [7:0] bitNew;

   // Request decode: nothing is written unless a request is present in this cycle.
   always @* begin
      ramWe = 1'b0;
      ramWAddr = reqAddr;
      ramWData = reqData;
      sfrWe = 1'b0;
      sfrWAddr = reqAddr;
      sfrWData = reqData;
      spPush = 1'b0;
      spPop = 1'b0;
      mulDo = 1'b0;
      rdData = `RST_ZERO_BYTE;
      bitByte = bitInSfr ? sfrRead(bitByteAddr) : ramRdA;
      bitNew = bitByte;
      bitNew[bitPos] = reqBitValue;
      if (reqValid) begin
         case (reqOp)
            `OP_DIRECT: begin
               if (directToSfr) begin
                  // Direct upper addresses never reach the upper scratchpad bytes.
                  rdData = sfrRead(reqAddr);
                  sfrWe = reqWrite;
               end else begin
                  rdData = ramRdA;
                  ramWe = reqWrite;
               end
            end
            `OP_INDIRECT: begin
               rdData = ramRdB;
               ramWe = reqWrite;
               ramWAddr = ramRdA;
            end
            `OP_WORKREG: begin
               rdData = ramRdA;
               ramWe = reqWrite;
               ramWAddr = workRegAddr;
            end
            `OP_BIT: begin
               rdData = bitByte;
               if (reqWrite) begin
                  // Read-modify-write of one bit; the rest of the byte is kept.
                  // A bit write to an SFR without storage reads 00h and then writes nowhere.
                  if (bitInSfr) begin
                     sfrWe = 1'b1;
                     sfrWAddr = bitByteAddr;
                     sfrWData = bitNew;
                  end else begin
                     ramWe = 1'b1;
                     ramWAddr = bitByteAddr;
                     ramWData = bitNew;
                  end
               end
            end
            `OP_PUSH: begin
               spPush = 1'b1;
               ramWe = 1'b1;
               ramWAddr = spInc;
            end
            `OP_POP: begin
               rdData = ramRdA;
               spPop = 1'b1;
            end
            `OP_MULTIPLY: begin
               mulDo = 1'b1;
               rdData = product[7:0];
            end
            default: rdData = `RST_ZERO_BYTE;
         endcase
      end
   end

   // One write strobe per defined SFR; any other address in SFR space has no storage at all.
   wire wrPortZero = sfrWe && (sfrWAddr == `ADDR_PORT_ZERO_LATCH);
   wire wrStack = sfrWe && (sfrWAddr == `ADDR_STACK_POINTER);
   wire wrPortOne = sfrWe && (sfrWAddr == `ADDR_PORT_ONE_LATCH);
   wire wrStatus = sfrWe && (sfrWAddr == `ADDR_STATUS_WORD);
   wire wrArith = sfrWe && (sfrWAddr == `ADDR_ARITH_RESULT);
   wire wrMulHigh = sfrWe && (sfrWAddr == `ADDR_MULTIPLY_HIGH);

   reg [7:0] stack_pointer_d;
   reg [7:0] arith_result_reg_d;
   reg [7:0] multiply_high_reg_d;

   // Stack and multiply effects take precedence over a same-cycle byte write of the same register.
   always @* begin
      stack_pointer_d = stack_pointer_q;
      if (wrStack) begin
         stack_pointer_d = sfrWData;
      end
      if (spPush) begin
         stack_pointer_d = spInc;
      end
      if (spPop) begin
         stack_pointer_d = spDec;
      end
   end

   always @* begin
      arith_result_reg_d = arith_result_reg_q;
      multiply_high_reg_d = multiply_high_reg_q;
      if (wrArith) begin
         arith_result_reg_d = sfrWData;
      end
      if (wrMulHigh) begin
         multiply_high_reg_d = sfrWData;
      end
      if (mulDo) begin
         arith_result_reg_d = product[7:0];
         multiply_high_reg_d = product[15:8];
      end
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stack_pointer_q <= `RST_STACK_POINTER;
      end else begin
         stack_pointer_q <= stack_pointer_d;
      end
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         arith_result_reg_q <= `RST_ZERO_BYTE;
         multiply_high_reg_q <= `RST_ZERO_BYTE;
      end else begin
         arith_result_reg_q <= arith_result_reg_d;
         multiply_high_reg_q <= multiply_high_reg_d;
      end
   end

   // Port latches reset to all ones so that the pins come up released.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_zero_latch_q <= `RST_PORT_LATCH;
      end else if (wrPortZero) begin
         port_zero_latch_q <= sfrWData;
      end
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_one_latch_q <= `RST_PORT_LATCH;
      end else if (wrPortOne) begin
         port_one_latch_q <= sfrWData;
      end
   end

   // Bank select and carry share this byte, so a bit write to either rewrites it whole.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_word_q <= `RST_ZERO_BYTE;
      end else if (wrStatus) begin
         status_word_q <= sfrWData;
      end
   end

   // Read data is registered so that every answer comes exactly one cycle after its request.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rspData_q <= 8'h00;
         rspBit_q <= 1'b0;
         rspValid_q <= 1'b0;
      end else begin
         rspData_q <= rdData;
         rspBit_q <= bitByte[bitPos];
         rspValid_q <= reqValid;
      end
   end

   // The mirrors lag the live registers by one cycle; that keeps every output straight off a flip-flop.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         portZeroOut_q <= `RST_PORT_LATCH;
         portOneOut_q <= `RST_PORT_LATCH;
         stackPointerOut_q <= `RST_STACK_POINTER;
         carryOut_q <= 1'b0;
      end else begin
         portZeroOut_q <= port_zero_latch_q;
         portOneOut_q <= port_one_latch_q;
         stackPointerOut_q <= stack_pointer_q;
         carryOut_q <= status_word_q[`STATUS_CARRY_BIT];
      end
   end
endmodule // core_data_space_decoder

// >>> rtl/scratch_ram.v
// Scratchpad byte storage of the core, 256 flip-flop bytes addressed by index.
`timescale 1ns/10ps
module scratch_ram #(
   parameter DEPTH = 256
) (
   input wire sys_clk,
   input wire reset_n,
   input wire writeEn,
   input wire [7:0] writeAddr,
   input wire [7:0] writeData,
   input wire [7:0] readAddrA,
   output wire [7:0] readDataA,
   input wire [7:0] readAddrB,
   output wire [7:0] readDataB
);
   reg [7:0] mem_q [0:DEPTH-1];
   genvar i;
   generate
      for (i = 0; i < DEPTH; i = i + 1) begin : g_byte
         always @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               mem_q[i] <= 8'h00;
            end else if (writeEn && ({24'h0, writeAddr} == i)) begin
               mem_q[i] <= writeData;
            end
         end
      end
   endgenerate
   assign readDataA = mem_q[readAddrA];
   assign readDataB = mem_q[readAddrB];
endmodule // scratch_ram

// >>> verification/core_issuer.sv
// Model of the core execution side that issues one data space request at a time.
`timescale 1ns/10ps
module core_issuer (
   input logic sys_clk,
   output logic reqValid,
   output logic [2:0] reqOp,
   output logic reqWrite,
   output logic [7:0] reqAddr,
   output logic [7:0] reqData,
   output logic reqBitValue
);
   initial begin
      reqValid = 1'h0;
      {reqOp, reqWrite, reqAddr, reqData, reqBitValue} = '0;
   end
   // Idle fields are inverted so that a stale request can never pass for a live one.
   task automatic issue(input logic [20:0] r);
      @(negedge sys_clk);
      {reqOp, reqWrite, reqAddr, reqData, reqBitValue} = r;
      reqValid = 1'h1;
      @(negedge sys_clk);
      reqValid = 1'h0;
      {reqOp, reqWrite, reqAddr, reqData, reqBitValue} = ~r;
   endtask
endmodule // core_issuer

// >>> verification/core_space_chk.sv
// Port assertions for the core data space decoder.
`timescale 1ns/10ps
`include "core_data_regs.vh"
module core_space_chk (
   input logic sys_clk,
   input logic reset_n,
   input logic reqValid,
   input logic [2:0] reqOp,
   input logic reqWrite,
   input logic [7:0] reqAddr,
   input logic [7:0] reqData,
   input logic reqBitValue,
   input logic [7:0] rspData_q,
   input logic rspValid_q,
   input logic [7:0] portZeroOut_q,
   input logic [7:0] portOneOut_q,
   input logic [7:0] stackPointerOut_q,
   input logic carryOut_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_rsp_follows: assert property (reqValid |=> rspValid_q) else $error("no response");
   a_rsp_stray: assert property (!reqValid |=> !rspValid_q) else $error("stray response");
   a_sp_reset: assert property ($rose(reset_n) |-> stackPointerOut_q == 8'h07) else $error("sp reset");
   // Only a push or pop with an idle cycle before it is judged, since the mirror lags the pointer.
   a_push_inc: assert property (reqValid && reqOp == `OP_PUSH && !$past(reqValid)
      |-> ##2 stackPointerOut_q == $past(stackPointerOut_q, 2) + 8'h01) else $error("push pointer");
   a_pop_dec: assert property (reqValid && reqOp == `OP_POP && !$past(reqValid)
      |-> ##2 stackPointerOut_q == $past(stackPointerOut_q, 2) - 8'h01) else $error("pop pointer");
   a_unassigned_zero: assert property (reqValid && reqOp == `OP_DIRECT && reqAddr[7:3] == 5'h11
      |=> rspData_q == 8'h00) else $error("unassigned read");
   a_port_zero_wr: assert property (reqValid && reqOp == `OP_DIRECT && reqWrite && reqAddr == 8'h80
      |=> ##1 portZeroOut_q == $past(reqData, 2)) else $error("port zero write");
   a_port_one_wr: assert property (reqValid && reqOp == `OP_DIRECT && reqWrite && reqAddr == 8'h90
      |=> ##1 portOneOut_q == $past(reqData, 2)) else $error("port one write");
   a_carry_bit: assert property (reqValid && reqOp == `OP_BIT && reqWrite && reqAddr == 8'hd7
      |=> ##1 carryOut_q == $past(reqBitValue, 2)) else $error("carry bit");
   c_push: cover property (reqValid && reqOp == `OP_PUSH);
   c_pop: cover property (reqValid && reqOp == `OP_POP);
   c_mul: cover property (reqValid && reqOp == `OP_MULTIPLY);
endmodule // core_space_chk
bind core_data_space_decoder core_space_chk i_chk (.sys_clk(sys_clk), .reset_n(reset_n), .reqValid(reqValid),
   .reqOp(reqOp), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqBitValue(reqBitValue),
   .rspData_q(rspData_q), .rspValid_q(rspValid_q), .portZeroOut_q(portZeroOut_q), .portOneOut_q(portOneOut_q),
   .stackPointerOut_q(stackPointerOut_q), .carryOut_q(carryOut_q));

// >>> verification/tb_top.sv
// Self-checking bench for the core data space decoder.
`timescale 1ns/10ps
`include "core_data_regs.vh"
module tb_top;
   logic sys_clk = 1'h0;
   logic reset_n = 1'h0;
   logic reqValid, reqWrite, reqBitValue, rspBit_q, rspValid_q, carryOut_q;
   logic [2:0] reqOp;
   logic [7:0] reqAddr, reqData, rspData_q, portZeroOut_q, portOneOut_q, stackPointerOut_q;
   logic [7:0] ram [256];
   logic [7:0] sp, p0, p1, status_word, acc, bv, old, ea;
   logic [7:0] pick [8] = '{8'h80, 8'h81, 8'h90, 8'hd0, 8'he0, 8'hf0, 8'h88, 8'hd7};
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   always #25 sys_clk = ~sys_clk;
   core_data_space_decoder i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reqValid(reqValid), .reqOp(reqOp),
      .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqBitValue(reqBitValue), .rspData_q(rspData_q),
      .rspBit_q(rspBit_q), .rspValid_q(rspValid_q), .portZeroOut_q(portZeroOut_q), .portOneOut_q(portOneOut_q),
      .stackPointerOut_q(stackPointerOut_q), .carryOut_q(carryOut_q));
   core_issuer i_core (.sys_clk(sys_clk), .reqValid(reqValid), .reqOp(reqOp), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqData(reqData), .reqBitValue(reqBitValue));
   task automatic finish_test;
      $display("Checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_fail++;
         finish_test();
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [7:0] rdSfr(input logic [7:0] a);
      case (a)
         `ADDR_PORT_ZERO_LATCH: return p0;
         `ADDR_STACK_POINTER: return sp;
         `ADDR_PORT_ONE_LATCH: return p1;
         `ADDR_STATUS_WORD: return status_word;
         `ADDR_ARITH_RESULT: return acc;
         `ADDR_MULTIPLY_HIGH: return bv;
         default: return a[7] ? 8'h00 : ram[a];
      endcase
   endfunction
   task automatic wrSfr(input logic [7:0] a, input logic [7:0] d);
      case (a)
         `ADDR_PORT_ZERO_LATCH: p0 = d;
         `ADDR_STACK_POINTER: sp = d;
         `ADDR_PORT_ONE_LATCH: p1 = d;
         `ADDR_STATUS_WORD: status_word = d;
         `ADDR_ARITH_RESULT: acc = d;
         `ADDR_MULTIPLY_HIGH: bv = d;
         default: if (!a[7]) ram[a] = d;
      endcase
   endtask
   // The bit value rides on the low data bit to keep the call short.
   task automatic step(input logic [2:0] op, input logic w, input logic [7:0] a, input logic [7:0] d);
      logic [15:0] pr;
      ea = a;
      case (op)
         `OP_INDIRECT: ea = ram[{3'h0, status_word[4:3], 2'h0, a[0]}];
         `OP_WORKREG: ea = {3'h0, status_word[4:3], a[2:0]};
         `OP_BIT: ea = a[7] ? {a[7:3], 3'h0} : 8'h20 + a[6:3];
         `OP_PUSH: ea = sp + 8'h01;
         `OP_POP: ea = sp;
         default: ;
      endcase
      old = (op == `OP_DIRECT || op == `OP_BIT) ? rdSfr(ea) : ram[ea];
      pr = acc * bv;
      i_core.issue({op, w, a, d, d[0]});
      if (op != `OP_PUSH && (op > `OP_WORKREG || !w)) begin
         chk("rspData", rspData_q, op == `OP_MULTIPLY ? pr[7:0] : old);
      end
      chk("rspValid", {7'h0, rspValid_q}, 8'h01);
      if (op == `OP_BIT) chk("rspBit", {7'h0, rspBit_q}, {7'h0, old[a[2:0]]});
      if (op == `OP_MULTIPLY) {bv, acc} = pr;
      if (op == `OP_POP) sp = sp - 8'h01;
      if (op == `OP_PUSH) sp = ea;
      if (op == `OP_PUSH || (w && (op == `OP_INDIRECT || op == `OP_WORKREG))) ram[ea] = d;
      if (w && op == `OP_DIRECT) wrSfr(ea, d);
      if (w && op == `OP_BIT) begin
         old[a[2:0]] = d[0];
         wrSfr(ea, old);
      end
      @(posedge sys_clk);
      #1;
      chk("stack", stackPointerOut_q, sp);
      chk("port0", portZeroOut_q, p0);
      chk("port1", portOneOut_q, p1);
      chk("carry", {7'h0, carryOut_q}, {7'h0, status_word[7]});
   endtask
   initial begin
      for (int i = 0; i < 256; i++) ram[i] = 8'h00;
      {sp, p0, p1, status_word, acc, bv} = {8'h07, 8'hff, 8'hff, 24'h0};
      void'($urandom(19662));
      repeat (16) @(negedge sys_clk);
      reset_n = 1'h1;
      chk("stackReset", stackPointerOut_q, 8'h07);
      step(`OP_DIRECT, 1'h1, 8'h81, 8'h9b);
      step(`OP_PUSH, 1'h0, 8'h00, 8'h55);
      step(`OP_DIRECT, 1'h0, 8'h9c, 8'h00);
      step(`OP_WORKREG, 1'h1, 8'h00, 8'h9c);
      step(`OP_INDIRECT, 1'h0, 8'h00, 8'h00);
      step(`OP_POP, 1'h0, 8'h00, 8'h00);
      step(`OP_DIRECT, 1'h1, 8'he0, 8'h12);
      step(`OP_DIRECT, 1'h1, 8'hf0, 8'h3b);
      step(`OP_MULTIPLY, 1'h0, 8'h00, 8'h00);
      step(`OP_DIRECT, 1'h1, 8'hd0, 8'h10);
      step(`OP_WORKREG, 1'h1, 8'h01, 8'h77);
      step(`OP_DIRECT, 1'h0, 8'h11, 8'h00);
      step(`OP_BIT, 1'h1, 8'hd7, 8'h01);
      step(`OP_BIT, 1'h1, 8'h5e, 8'h01);
      step(`OP_DIRECT, 1'h0, 8'h2b, 8'h00);
      repeat (500) step(3'h1 + 3'($urandom % 7), 1'($urandom), $urandom % 2 ? pick[$urandom % 8] : 8'($urandom),
         8'($urandom));
      finish_test();
   end
endmodule // tb_top
